// ### core/ldedec_top.v
// large-page directory entry decoder: request classification, outputs and registers
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ldedec_defs.vh"

module ldedec_top #(
  parameter PAW = 39,
  parameter VW  = 48,
  parameter DW  = 32,
  parameter TW  = 8
) (
  // clock and reset
  input  wire           mclk_i,
  input  wire           rst_i,
  // translation request with its fetched entry
  input  wire           req_valid_i,
  input  wire           req_write_i,
  input  wire [TW-1:0]  req_tag_i,
  input  wire [VW-1:0]  req_vaddr_i,
  input  wire [DW-1:0]  req_wdata_i,
  input  wire [63:0]    req_entry_i,
  // register port
  input  wire [7:0]     reg_addr_i,
  input  wire [31:0]    reg_wdata_i,
  input  wire           reg_we_i,
  input  wire           reg_re_i,
  output wire [31:0]    reg_rdata_o,
  // memory access
  output wire           mem_valid_o,
  output wire           mem_write_o,
  output wire [TW-1:0]  mem_tag_o,
  output wire [PAW-1:0] mem_addr_o,
  output wire [DW-1:0]  mem_wdata_o,
  output wire           mem_gpa_o,
  output wire           mem_attr_idx_o,
  output wire           mem_cache_dis_o,
  output wire           mem_wthru_o,
  // null completion
  output wire           cpl_valid_o,
  output wire [TW-1:0]  cpl_tag_o,
  output wire [DW-1:0]  cpl_data_o,
  // dropped write
  output wire           drop_o,
  output wire [TW-1:0]  drop_tag_o,
  // translation fault
  output wire           fault_o,
  output wire [1:0]     fault_kind_o,
  output wire [TW-1:0]  fault_tag_o
);

  localparam NCNT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire [PAW-1:0] paddr_w;
  wire           absent_w;
  wire           null_w;
  wire           wdeny_w;
  wire [2:0]     mtype_w;
  reg  [31:0]    ctrl_q;

  ldedec_addr #(
    .PAW (PAW),
    .VW  (VW)
  ) u_addr (
    .entry_i (req_entry_i),
    .vaddr_i (req_vaddr_i),
    .paddr_o (paddr_w)
  );

  ldedec_chk u_chk (
    .entry_i    (req_entry_i),
    .write_i    (req_write_i),
    .coherent_i (ctrl_q[`LDE_CTL_COHERENT]),
    .absent_o   (absent_w),
    .null_o     (null_w),
    .wdeny_o    (wdeny_w),
    .mtype_o    (mtype_w)
  );

  // priority: absent entry, then null page, then write permission
  reg do_fault;
  reg do_cpl;
  reg do_drop;
  reg do_mem;
  reg [1:0] fkind;

  always @* begin
    do_fault = 1'b0;
    do_cpl   = 1'b0;
    do_drop  = 1'b0;
    do_mem   = 1'b0;
    fkind    = `LDE_FLT_NONE;
    // a missing entry is judged first: its other bits carry no meaning
    if (req_valid_i) begin
      // an entry left absent by software lands here
      if (absent_w) begin
        do_fault = 1'b1;
        fkind    = `LDE_FLT_ABSENT;
      end else if (null_w) begin
        do_cpl  = ~req_write_i;
        do_drop = req_write_i;
      end else if (wdeny_w) begin
        // a null write never gets here, so it is dropped rather than refused
        // write refused
        do_fault = 1'b1;
        fkind    = `LDE_FLT_WDENY;
      end else begin
        do_mem = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  reg           mem_valid_q;
  reg           mem_write_q;
  reg [TW-1:0]  mem_tag_q;
  reg [PAW-1:0] mem_addr_q;
  reg [DW-1:0]  mem_wdata_q;
  reg           mem_gpa_q;
  reg [2:0]     mem_type_q;
  reg           cpl_valid_q;
  reg [TW-1:0]  cpl_tag_q;
  reg [DW-1:0]  cpl_data_q;
  reg           drop_q;
  reg [TW-1:0]  drop_tag_q;
  reg           fault_q;
  reg [1:0]     fault_kind_q;
  reg [TW-1:0]  fault_tag_q;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      mem_valid_q  <= 1'b0;
      mem_write_q  <= 1'b0;
      mem_tag_q    <= {TW{1'b0}};
      mem_addr_q   <= {PAW{1'b0}};
      mem_wdata_q  <= {DW{1'b0}};
      mem_gpa_q    <= 1'b0;
      mem_type_q   <= 3'h0;
      cpl_valid_q  <= 1'b0;
      cpl_tag_q    <= {TW{1'b0}};
      cpl_data_q   <= {DW{1'b0}};
      drop_q       <= 1'b0;
      drop_tag_q   <= {TW{1'b0}};
      fault_q      <= 1'b0;
      fault_kind_q <= `LDE_FLT_NONE;
      fault_tag_q  <= {TW{1'b0}};
    end else begin
      // one outcome pulse per request, one cycle after it is taken
      mem_valid_q <= do_mem;
      cpl_valid_q <= do_cpl;
      drop_q      <= do_drop;
      fault_q     <= do_fault;
      // side fields hold between pulses so they are stable for the consumer
      if (do_mem) begin
        mem_write_q <= req_write_i;
        mem_tag_q   <= req_tag_i;
        mem_addr_q  <= paddr_w;
        mem_wdata_q <= req_write_i ? req_wdata_i : {DW{1'b0}};
        mem_gpa_q   <= ctrl_q[`LDE_CTL_NESTED];
        mem_type_q  <= mtype_w;
      end
      if (do_cpl) begin
        cpl_tag_q  <= req_tag_i;
        cpl_data_q <= {DW{1'b0}};
      end
      if (do_drop) begin
        drop_tag_q <= req_tag_i;
      end
      if (do_fault) begin
        fault_kind_q <= fkind;
        fault_tag_q  <= req_tag_i;
      end
    end
  end

  assign mem_valid_o  = mem_valid_q;
  assign mem_write_o  = mem_write_q;
  assign mem_tag_o    = mem_tag_q;
  assign mem_addr_o   = mem_addr_q;
  assign mem_wdata_o  = mem_wdata_q;
  assign mem_gpa_o    = mem_gpa_q;
  assign mem_attr_idx_o  = mem_type_q[2];
  assign mem_cache_dis_o = mem_type_q[1];
  assign mem_wthru_o     = mem_type_q[0];
  assign cpl_valid_o  = cpl_valid_q;
  assign cpl_tag_o    = cpl_tag_q;
  assign cpl_data_o   = cpl_data_q;
  assign drop_o       = drop_q;
  assign drop_tag_o   = drop_tag_q;
  assign fault_o      = fault_q;
  assign fault_kind_o = fault_kind_q;
  assign fault_tag_o  = fault_tag_q;

  ////////////////////////////////////////////////////////////////////////////
  // control, sticky status and last fault address

  reg [2:0]    sticky_q;
  reg [VW-1:0] last_q;
  wire         wr_ctrl;
  wire         wr_status;
  wire [2:0]   st_set;
  wire [2:0]   st_clr;

  assign wr_ctrl   = reg_we_i && (reg_addr_i == `LDE_OFS_CTRL);
  assign wr_status = reg_we_i && (reg_addr_i == `LDE_OFS_STATUS);
  assign st_set    = {do_fault && (fkind == `LDE_FLT_WDENY), do_cpl | do_drop, do_fault};
  assign st_clr    = wr_status ? reg_wdata_i[2:0] : 3'h0;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_q   <= `LDE_CTL_RESET;
      sticky_q <= 3'h0;
      last_q   <= {VW{1'b0}};
    end else begin
      if (wr_ctrl) begin
        // only the three defined control bits are kept; the rest read back as zero
        // supervisor write-protect is stored for software but steers nothing
        ctrl_q <= {29'h0, reg_wdata_i[`LDE_CTL_SWPE:0]};
      end
      // write one to clear; a new event in the same cycle wins
      sticky_q <= (sticky_q & ~st_clr) | st_set;
      // null outcomes are not faults and leave the captured address alone
      if (do_fault) begin
        last_q <= req_vaddr_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // saturating event counters; a write to their offset restarts them at zero, or at one if their event comes in that cycle

  wire [NCNT-1:0]    cnt_ev;
  wire [32*NCNT-1:0] cnt_w;

  // saturating, not wrapping, so software never sees a small count after overflow
  assign cnt_ev = {st_set[2], st_set[1], st_set[0], req_valid_i};

  genvar gi;
  generate
    for (gi = 0; gi < NCNT; gi = gi + 1) begin : g_cnt
      localparam [31:0] OFS_W = `LDE_OFS_CNT0 + 4 * gi;
      wire       cnt_clr = reg_we_i && (reg_addr_i == OFS_W[7:0]);
      reg [31:0] q;
      always @(posedge mclk_i) begin
        if (rst_i) begin
          q <= 32'h0;
        end else if (cnt_clr) begin
          q <= {31'h0, cnt_ev[gi]};
        end else if (cnt_ev[gi] && (q != 32'hFFFFFFFF)) begin
          q <= q + 32'h1;
        end
      end
      assign cnt_w[32*gi +: 32] = q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read port

  reg [31:0] rdata_q;
  reg [31:0] rmux;
  wire [63:0] last_w;

  assign last_w = {{(64-VW){1'b0}}, last_q};

  always @* begin
    case (reg_addr_i)
      `LDE_OFS_CTRL:        rmux = ctrl_q;
      `LDE_OFS_STATUS:      rmux = {29'h0, sticky_q};
      `LDE_OFS_CNT0:        rmux = cnt_w[31:0];
      `LDE_OFS_CNT1:        rmux = cnt_w[63:32];
      `LDE_OFS_CNT2:        rmux = cnt_w[95:64];
      `LDE_OFS_CNT3:        rmux = cnt_w[127:96];
      `LDE_OFS_LASTLO:      rmux = last_w[31:0];
      `LDE_OFS_LASTHI:      rmux = last_w[63:32];
      // unmapped offsets read as zero
      default:              rmux = 32'h0;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_re_i ? rmux : 32'h0;
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule

// ### core/ldedec_defs.vh
// constants for the large-page directory entry decoder
// Overview of operation
// - page base is entry bits from address-width limit minus one down to 21.
// - with nested translation enabled, the base is a guest address needing more translation.
// - entry bits above address width and bits 20:10, 8, 6:5, 2 are ignored.
// - null flag set: a read makes no memory access and returns zeros, null completion.
// - null flag set: every write to the page is silently dropped.
// - in the coherency domain, bits 7, 4 and 3 go out as memory-type selectors.
// - write-permit bit 1 clear denies writes for user-level requests in the mapped region.
// - no supervisor contexts; all requests checked as user level, write-protect never applies.
`ifndef LDEDEC_DEFS_VH
`define LDEDEC_DEFS_VH

// entry field positions
`define LDE_BIT_PRESENT   0
`define LDE_BIT_WRITE     1
`define LDE_BIT_WTHRU     3
`define LDE_BIT_CDIS      4
`define LDE_BIT_PATIDX    7
`define LDE_BIT_NULL      9
`define LDE_BASE_LSB      21

// fault kinds
`define LDE_FLT_NONE      2'h0
`define LDE_FLT_ABSENT    2'h1
`define LDE_FLT_WDENY     2'h2

// register offsets
`define LDE_OFS_CTRL      8'h00
`define LDE_OFS_STATUS    8'h04
`define LDE_OFS_CNT0      8'h08
`define LDE_OFS_CNT1      8'h0C
`define LDE_OFS_CNT2      8'h10
`define LDE_OFS_CNT3      8'h14
`define LDE_OFS_LASTLO    8'h18
`define LDE_OFS_LASTHI    8'h1C

// control fields and reset value
`define LDE_CTL_NESTED    0
`define LDE_CTL_COHERENT  1
`define LDE_CTL_SWPE      2
`define LDE_CTL_RESET     32'h00000002

// sticky status fields
`define LDE_ST_FAULT      0
`define LDE_ST_NULL       1
`define LDE_ST_DENY       2

`endif

// ### core/ldedec_addr.v
// forms the translated address from a 2MB directory entry and a request address
`timescale 1ns/1ps
`include "ldedec_defs.vh"

module ldedec_addr #(
  parameter PAW = 39,
  parameter VW  = 48
) (
  // inputs
  input  wire [63:0]    entry_i,
  input  wire [VW-1:0]  vaddr_i,
  // output
  output wire [PAW-1:0] paddr_o
);

  // bits above PAW-1 and 20:10 never reach the concatenated address
  assign paddr_o = {entry_i[PAW-1:`LDE_BASE_LSB], vaddr_i[`LDE_BASE_LSB-1:0]};

endmodule

// ### core/ldedec_chk.v
// classifies a request against the flag bits of a 2MB directory entry
`timescale 1ns/1ps
`include "ldedec_defs.vh"

module ldedec_chk (
  // inputs
  input  wire [63:0] entry_i,
  input  wire        write_i,
  input  wire        coherent_i,
  // outputs
  output wire        absent_o,
  output wire        null_o,
  output wire        wdeny_o,
  output wire [2:0]  mtype_o
);

  assign absent_o = ~entry_i[`LDE_BIT_PRESENT];
  assign null_o   = entry_i[`LDE_BIT_NULL];
  // always user level, so write-protect enable is not consulted
  assign wdeny_o  = write_i & ~entry_i[`LDE_BIT_WRITE];
  // bits 8, 6:5 and 2 are not looked at
  assign mtype_o  = coherent_i ? {entry_i[`LDE_BIT_PATIDX], entry_i[`LDE_BIT_CDIS], entry_i[`LDE_BIT_WTHRU]}
                               : 3'h0;

endmodule

// ### bench/ldedec_props_chk.sv
// port assertions for the large-page entry decoder
`timescale 1ns/1ps
module ldedec_props #(
  parameter PAW = 39,
  parameter VW  = 48,
  parameter DW  = 32,
  parameter TW  = 8
) (
  input wire           mclk_i,
  input wire           rst_i,
  input wire           req_valid_i,
  input wire           req_write_i,
  input wire [TW-1:0]  req_tag_i,
  input wire [VW-1:0]  req_vaddr_i,
  input wire [DW-1:0]  req_wdata_i,
  input wire [63:0]    req_entry_i,
  input wire           reg_re_i,
  input wire [31:0]    reg_rdata_o,
  input wire           mem_valid_o,
  input wire           mem_write_o,
  input wire [PAW-1:0] mem_addr_o,
  input wire [DW-1:0]  mem_wdata_o,
  input wire           cpl_valid_o,
  input wire [TW-1:0]  cpl_tag_o,
  input wire [DW-1:0]  cpl_data_o,
  input wire           drop_o,
  input wire [TW-1:0]  drop_tag_o,
  input wire           fault_o,
  input wire [1:0]     fault_kind_o
);
  wire           go_w = req_valid_i & req_entry_i[0] & ~req_entry_i[9];
  wire           ok_w = go_w & (~req_write_i | req_entry_i[1]);
  wire [PAW-1:0] pa_w = {req_entry_i[PAW-1:21], req_vaddr_i[20:0]};
  wire [DW-1:0]  wd_w = req_write_i ? req_wdata_i : {DW{1'h0}};
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////
  chk_one_outcome: assert property (req_valid_i |=>
    $onehot({mem_valid_o, cpl_valid_o, drop_o, fault_o})) else $error("not exactly one outcome");
  chk_quiet_idle: assert property (!req_valid_i |=>
    !(mem_valid_o | cpl_valid_o | drop_o | fault_o)) else $error("outcome without request");
  chk_absent_fault: assert property (req_valid_i && !req_entry_i[0] |=>
    fault_o && fault_kind_o == 2'h1) else $error("absent entry not faulted");
  chk_null_read: assert property (go_w == 1'h0 && req_valid_i && req_entry_i[0] && !req_write_i |=>
    cpl_valid_o && cpl_data_o == 0 && cpl_tag_o == $past(req_tag_i)) else $error("null read wrong");
  chk_null_drop: assert property (req_valid_i && req_entry_i[0] && req_entry_i[9] && req_write_i |=>
    drop_o && drop_tag_o == $past(req_tag_i)) else $error("null write not dropped");
  chk_write_deny: assert property (go_w && req_write_i && !req_entry_i[1] |=>
    fault_o && fault_kind_o == 2'h2) else $error("write not denied");
  chk_base_addr: assert property (ok_w |=>
    mem_valid_o && mem_addr_o == $past(pa_w)) else $error("translated address wrong");
  chk_mem_data: assert property (ok_w |=>
    mem_write_o == $past(req_write_i) && mem_wdata_o == $past(wd_w)) else $error("access data wrong");
  chk_read_idle: assert property (!reg_re_i |=> reg_rdata_o == 32'h0) else $error("read data outside slot");
endmodule

bind ldedec_top ldedec_props #(.PAW(PAW), .VW(VW), .DW(DW), .TW(TW)) props_u (.*);

// ### bench/ldedec_eng.sv
// request source standing in for the graphics engines
`timescale 1ns/1ps
module ldedec_eng (
  input  wire         mclk_i,
  output logic        req_valid_o = 1'h0,
  output logic        req_write_o = 1'h0,
  output logic [7:0]  req_tag_o   = 8'h00,
  output logic [47:0] req_vaddr_o = 48'h0,
  output logic [31:0] req_wdata_o = 32'h0,
  output logic [63:0] req_entry_o = 64'h0
);
  // present flag comes from the caller so absent entries can be sent
  task send(input logic w, input logic [7:0] t, input logic [47:0] va, input logic [31:0] d,
            input logic [63:0] e);
    @(posedge mclk_i);
    req_valid_o <= 1'h1;
    req_write_o <= w;
    req_tag_o   <= t;
    req_vaddr_o <= va;
    req_wdata_o <= d;
    req_entry_o <= e;
  endtask
  // released tag, entry and data lines flip so stale values never look valid
  task idle;
    @(posedge mclk_i);
    req_valid_o <= 1'h0;
    req_tag_o   <= ~req_tag_o;
    req_entry_o <= ~req_entry_o;
    req_wdata_o <= ~req_wdata_o;
  endtask
endmodule

// ### bench/large_page_dir_entry_decode_bench.sv
// self-checking bench for the large-page entry decoder
`timescale 1ns/1ps
module large_page_dir_entry_decode_bench;
  localparam logic [63:0] IGN  = 64'hFFFF_FF80_001F_FD64;
  localparam logic [63:0] BASE = 64'h0000_0055_AA20_0000;
  localparam logic [47:0] VA   = 48'h1234_5678_9ABC;
  logic        mclk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_we_i = 1'h0;
  logic        reg_re_i = 1'h0;
  wire         req_valid_i, req_write_i, mem_valid_o, mem_write_o, mem_gpa_o;
  wire         mem_attr_idx_o, mem_cache_dis_o, mem_wthru_o;
  wire [2:0]   attr_w = {mem_attr_idx_o, mem_cache_dis_o, mem_wthru_o};
  wire         cpl_valid_o, drop_o, fault_o;
  wire [7:0]   req_tag_i, mem_tag_o, cpl_tag_o, drop_tag_o, fault_tag_o;
  wire [47:0]  req_vaddr_i;
  wire [31:0]  req_wdata_i, reg_rdata_o, mem_wdata_o, cpl_data_o;
  wire [63:0]  req_entry_i;
  wire [38:0]  mem_addr_o;
  wire [1:0]   fault_kind_o;
  int          bad_count = 0;
  int          n_checks = 0;
  always #5 mclk_i = ~mclk_i;
  ldedec_top dut_u (.*);
  ldedec_eng eng_u (.mclk_i, .req_valid_o(req_valid_i), .req_write_o(req_write_i), .req_tag_o(req_tag_i),
                    .req_vaddr_o(req_vaddr_i), .req_wdata_o(req_wdata_i), .req_entry_o(req_entry_i));
  //////////////////////////////////////////////////////////////////
  task cmp(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_we_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_we_i <= 1'h0;
  endtask
  task reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    reg_re_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_re_i <= 1'h0;
    #1 cmp(reg_rdata_o, e);
  endtask
  // outcome order is {memory, completion, drop, fault}
  task outc(input logic [3:0] e);
    eng_u.idle();
    #1 cmp({mem_valid_o, cpl_valid_o, drop_o, fault_o}, e);
  endtask
  //////////////////////////////////////////////////////////////////
  task t_regs;
    reg_rd(8'h00, 32'h2);
    reg_rd(8'h04, 32'h0);
    reg_rd(8'h08, 32'h0);
    reg_rd(8'h40, 32'h0);
    $display("test regs done");
  endtask
  task t_map;
    eng_u.send(1'h0, 8'h11, VA, 32'h0, IGN | BASE | 64'h89);
    outc(4'h8);
    cmp(mem_addr_o, 39'h55_AA38_9ABC);
    cmp({mem_write_o, mem_tag_o, mem_gpa_o, attr_w, mem_wdata_o}, 45'h115_00000000);
    eng_u.send(1'h1, 8'h12, VA, 32'hCAFE_0001, BASE | 64'h13);
    outc(4'h8);
    cmp({mem_write_o, mem_tag_o, attr_w, mem_wdata_o}, 44'h892_CAFE0001);
    $display("test map done");
  endtask
  task t_nested;
    reg_wr(8'h00, 32'h1);
    eng_u.send(1'h0, 8'h31, VA, 32'h0, BASE | 64'h99);
    outc(4'h8);
    cmp({mem_gpa_o, attr_w}, 4'h8);
    reg_wr(8'h00, 32'h2);
    eng_u.send(1'h0, 8'h32, VA, 32'h0, BASE | 64'h99);
    outc(4'h8);
    cmp({mem_gpa_o, attr_w}, 4'h7);
    $display("test nested done");
  endtask
  task t_null;
    eng_u.send(1'h0, 8'h41, VA, 32'h0, BASE | 64'h203);
    outc(4'h4);
    cmp({cpl_tag_o, cpl_data_o}, 40'h41_00000000);
    eng_u.send(1'h1, 8'h42, VA, 32'h5555_AAAA, BASE | 64'h201);
    outc(4'h2);
    cmp(drop_tag_o, 8'h42);
    reg_rd(8'h10, 32'h2);
    $display("test null done");
  endtask
  task t_faults;
    reg_wr(8'h00, 32'h6);
    reg_rd(8'h00, 32'h6);
    eng_u.send(1'h1, 8'h51, VA, 32'h1, BASE | 64'h202);
    eng_u.send(1'h1, 8'h52, VA, 32'h2, BASE | 64'h01);
    #1 cmp({fault_o, fault_kind_o, fault_tag_o}, 11'h551);
    outc(4'h1);
    cmp({fault_kind_o, fault_tag_o}, 10'h252);
    reg_rd(8'h04, 32'h7);
    reg_rd(8'h0C, 32'h2);
    reg_rd(8'h14, 32'h1);
    reg_rd(8'h18, 32'h5678_9ABC);
    reg_rd(8'h1C, 32'h1234);
    reg_rd(8'h08, 32'h8);
    reg_wr(8'h04, 32'h7);
    reg_rd(8'h04, 32'h0);
    $display("test faults done");
  endtask
  //////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'h0;
    t_regs();
    t_map();
    t_nested();
    t_null();
    t_faults();
    print_verdict();
  end
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
